// file: design/controller_control_self_test_regs.sv
// Control and self-test register group of the micromirror array controller:
// version word, watchdog enable, self-test triggers, sync-error latch,
// channel 0 lane results and a maskable interrupt, all behind an APB slave.
// Assumes all inputs are synchronous to pclk and the master follows APB.
`timescale 1ns/10ps
module controller_control_self_test_regs
  import ctrl_regs_pkg::*;
#(
  parameter int LANES = 8,
  parameter logic [11:0] BUILD_NUMBER = 12'h000,
  parameter logic [7:0] MAJOR_VERSION = 8'h00,
  parameter logic [7:0] MINOR_VERSION = 8'h00
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctrl_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [ctrl_regs_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [ctrl_regs_pkg::DATA_W-1:0] prdata,
  // Watchdog control
  output logic watchdog_enable,
  // Self-test launch pulses
  output logic integrity_test_trigger,
  output logic low_speed_bus_test_trigger,
  // Self-test completion and results
  input wire logic integrity_test_done,
  input wire logic low_speed_bus_test_done,
  input wire logic [LANES-1:0] ch0_lane_pass,
  // Interface sync error event
  input wire logic sync_error_event,
  // Interrupt and latch state
  output logic sync_error_latch_clear,
  output logic irq
);
  import ctrl_regs_pkg::*;

  // Refuse lane counts the result word cannot carry
  if (LANES < 1 || LANES > DATA_W) begin : g_bad_lanes
    $error("LANES must be between 1 and 32");
  end

  // The hold counter must reach the 500 ns count without wrapping
  if (LATCH_CLEAR_HOLD_CYC >= (1 << HOLD_CNT_W)) begin : g_bad_hold
    $error("HOLD_CNT_W too narrow for the latch clear hold count");
  end

  // Bus phase state
  apb_state_t state_r;
  apb_state_t state_nxt;

  // Registered state
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic watchdog_enable_r;
  logic latch_clear_r;
  logic [LANES-1:0] lane_pass_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [HOLD_CNT_W-1:0] hold_cnt_r;
  logic hold_met_r;

  // Decoded strobes
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic lane0_strb;
  logic sync_error_flag;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_rd_clr;
  logic [DATA_W-1:0] version_word;

  // Per-register write strobes and the status read strobe
  logic wr_main_control;
  logic wr_self_test;
  logic wr_latch_clear;
  logic wr_irq_mask;
  logic rd_irq_status;

  // Address hit check for every mapped register
  always_comb begin
    case (paddr)
      ADDR_BITSTREAM_VERSION,
      ADDR_MAIN_CONTROL,
      ADDR_SELF_TEST_TRIGGER,
      ADDR_SYNC_ERROR_CLEAR,
      ADDR_SYNC_ERROR_STATUS,
      ADDR_LANE_TEST_RESULT_CH0,
      ADDR_IRQ_STATUS,
      ADDR_IRQ_MASK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Setup cycle detection and completion of the access phase
  assign setup_phase = psel && !penable;
  assign access_done = (state_r == APB_ACCESS) && psel && penable;
  assign wr_en = access_done && pwrite && addr_hit;
  assign rd_en = access_done && !pwrite && addr_hit;
  // All writable fields sit in byte lane 0
  assign lane0_strb = pstrb[0];

  // One decode per register keeps every write path gated the same way;
  // a write with byte 0 strobed off completes but changes nothing
  assign wr_main_control = wr_en && lane0_strb && (paddr == ADDR_MAIN_CONTROL);
  assign wr_self_test = wr_en && lane0_strb && (paddr == ADDR_SELF_TEST_TRIGGER);
  assign wr_latch_clear = wr_en && lane0_strb && (paddr == ADDR_SYNC_ERROR_CLEAR);
  assign wr_irq_mask = wr_en && lane0_strb && (paddr == ADDR_IRQ_MASK);
  assign rd_irq_status = rd_en && (paddr == ADDR_IRQ_STATUS);

  // Zero-wait slave: ready as soon as the access phase is seen.
  // No wait states are ever inserted, so every access completes
  // in its first access cycle.
  assign pready = access_done;
  assign pslverr = access_done && !addr_hit;

  // Phase sequencing
  // Access always falls back to idle; a setup that follows at once
  // is picked up again from idle in the very next cycle
  always_comb begin
    case (state_r)
      APB_IDLE: begin
        if (setup_phase) begin
          state_nxt = APB_ACCESS;
        end else begin
          state_nxt = APB_IDLE;
        end
      end
      APB_ACCESS: begin
        state_nxt = APB_IDLE;
      end
      default: begin
        state_nxt = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= APB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Build fields are fixed when the bitstream is built
  // Version word; the build level field is unused and stays zero
  always_comb begin
    version_word = RST_ZERO_WORD;
    version_word[BUILD_NUMBER_LSB +: BUILD_NUMBER_W] = BUILD_NUMBER;
    version_word[MAJOR_VERSION_LSB +: MAJOR_VERSION_W] = MAJOR_VERSION;
    version_word[MINOR_VERSION_LSB +: MINOR_VERSION_W] = MINOR_VERSION;
    version_word[BUILD_LEVEL_LSB +: BUILD_LEVEL_W] = 4'h0;
  end

  // Read mux; captured in the setup cycle so prdata comes from a flop
  // With zero wait states this costs no latency and keeps the
  // address decode out of the read data path
  always_comb begin
    rdata_nxt = RST_ZERO_WORD;
    case (paddr)
      ADDR_BITSTREAM_VERSION: begin
        rdata_nxt = version_word;
      end
      ADDR_MAIN_CONTROL: begin
        rdata_nxt[WATCHDOG_ENABLE_BIT] = watchdog_enable_r;
      end
      ADDR_SELF_TEST_TRIGGER: begin
        rdata_nxt = RST_ZERO_WORD;
      end
      ADDR_SYNC_ERROR_CLEAR: begin
        rdata_nxt[SYNC_ERROR_LATCH_CLEAR_BIT] = latch_clear_r;
      end
      ADDR_SYNC_ERROR_STATUS: begin
        rdata_nxt[SYNC_ERROR_FLAG_BIT] = sync_error_flag;
      end
      ADDR_LANE_TEST_RESULT_CH0: begin
        rdata_nxt[LANES-1:0] = lane_pass_r;
      end
      ADDR_IRQ_STATUS: begin
        rdata_nxt[IRQ_W-1:0] = irq_status;
      end
      ADDR_IRQ_MASK: begin
        rdata_nxt[IRQ_W-1:0] = irq_mask_r;
      end
      default: begin
        rdata_nxt = RST_ZERO_WORD;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= RST_ZERO_WORD;
    end else if (setup_phase && !pwrite) begin
      prdata_r <= rdata_nxt;
    end
  end

  // Holds until the next read setup, so a late sampler still sees it
  assign prdata = prdata_r;

  // Watchdog enable; runs by default until software writes zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_enable_r <= RST_WATCHDOG_ENABLE;
    end else if (wr_main_control) begin
      watchdog_enable_r <= pwdata[WATCHDOG_ENABLE_BIT];
    end
  end

  assign watchdog_enable = watchdog_enable_r;

  // Self-test launches; nothing is stored, so reads return zero
  trigger_pulse u_integrity_trigger (
    .clk(pclk),
    .rst_n(presetn),
    .fire(wr_self_test && pwdata[INTEGRITY_TEST_BIT]),
    .pulse(integrity_test_trigger)
  );

  trigger_pulse u_low_speed_trigger (
    .clk(pclk),
    .rst_n(presetn),
    .fire(wr_self_test && pwdata[LOW_SPEED_BUS_TEST_BIT]),
    .pulse(low_speed_bus_test_trigger)
  );

  // Latch clear bit, written to one and later back to zero by software
  // While it is high the flag stays at zero and new errors are dropped,
  // so an error inside the clear window is lost by design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_clear_r <= RST_SYNC_ERROR_LATCH_CLEAR;
    end else if (wr_latch_clear) begin
      latch_clear_r <= pwdata[SYNC_ERROR_LATCH_CLEAR_BIT];
    end
  end

  assign sync_error_latch_clear = latch_clear_r;

  // Hold-time monitor; an early release still arms, the flag only tells
  // Software owns the wait; the counter only measures it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_r <= '0;
      hold_met_r <= 1'b0;
    end else if (!latch_clear_r) begin
      hold_cnt_r <= '0;
      hold_met_r <= 1'b0;
    end else if (hold_cnt_r != HOLD_CNT_W'(LATCH_CLEAR_HOLD_CYC)) begin
      hold_cnt_r <= hold_cnt_r + 1'b1;
    end else begin
      hold_met_r <= 1'b1;
    end
  end

  // Sticky sync-error flag; the clear level wins over a new error
  // No clear pulse: only the clear register's level may drop the flag
  sticky_flag u_sync_error (
    .clk(pclk),
    .rst_n(presetn),
    .set(sync_error_event),
    .clr(1'b0),
    .hold(latch_clear_r),
    .flag(sync_error_flag)
  );

  // Channel 0 lane results, latched when the integrity test completes
  // A read during a running test still shows the previous run,
  // never a half-finished set of lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_pass_r <= '0;
    end else if (integrity_test_done) begin
      lane_pass_r <= ch0_lane_pass;
    end
  end

  // Interrupt mask
  // Masking gates only the output; status bits keep collecting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= RST_IRQ_MASK;
    end else if (wr_irq_mask) begin
      irq_mask_r <= pwdata[IRQ_W-1:0];
    end
  end

  // Interrupt events; the sync error event is gated like the flag itself
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_SYNC_ERROR_BIT] = sync_error_event && !latch_clear_r;
    irq_event[IRQ_INTEGRITY_DONE_BIT] = integrity_test_done;
    irq_event[IRQ_LOW_SPEED_DONE_BIT] = low_speed_bus_test_done;
  end

  // Read clears only bits that were actually returned, so an event
  // landing after the setup capture is never lost
  assign irq_rd_clr = rd_irq_status ? prdata_r[IRQ_W-1:0] : '0;

  // One sticky bit per interrupt source
  for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
    sticky_flag u_irq_bit (
      .clk(pclk),
      .rst_n(presetn),
      .set(irq_event[i]),
      .clr(irq_rd_clr[i]),
      .hold(1'b0),
      .flag(irq_status[i])
    );
  end

  // Level interrupt while any unmasked bit is pending
  // Combinational from flops, so irq follows status one cycle after the event
  assign irq = |(irq_status & irq_mask_r);

endmodule

// file: design/ctrl_regs_pkg.sv
// Register map, field layout, reset values and timing counts of the
// controller control and self-test register group.
// Assumes a 32-bit APB with byte addressing and a 200 MHz pclk.
package ctrl_regs_pkg;

  // Bus widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_BITSTREAM_VERSION = 32'h4000_0010;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_CONTROL = 32'h4000_0014;
  localparam logic [ADDR_W-1:0] ADDR_SELF_TEST_TRIGGER = 32'h4000_0018;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_ERROR_CLEAR = 32'h4000_0024;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_ERROR_STATUS = 32'h4000_0028;
  localparam logic [ADDR_W-1:0] ADDR_LANE_TEST_RESULT_CH0 = 32'h4000_002c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 32'h4000_0030;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 32'h4000_0034;

  // Version word field positions
  localparam int BUILD_NUMBER_LSB = 0;
  localparam int BUILD_NUMBER_W = 12;
  localparam int MAJOR_VERSION_LSB = 12;
  localparam int MAJOR_VERSION_W = 8;
  localparam int MINOR_VERSION_LSB = 20;
  localparam int MINOR_VERSION_W = 8;
  localparam int BUILD_LEVEL_LSB = 28;
  localparam int BUILD_LEVEL_W = 4;

  // Single-bit field positions
  localparam int WATCHDOG_ENABLE_BIT = 0;
  localparam int INTEGRITY_TEST_BIT = 0;
  localparam int LOW_SPEED_BUS_TEST_BIT = 1;
  localparam int SYNC_ERROR_LATCH_CLEAR_BIT = 0;
  localparam int SYNC_ERROR_FLAG_BIT = 0;

  // Interrupt status and mask layout
  localparam int IRQ_SYNC_ERROR_BIT = 0;
  localparam int IRQ_INTEGRITY_DONE_BIT = 1;
  localparam int IRQ_LOW_SPEED_DONE_BIT = 2;
  localparam int IRQ_W = 3;

  // Reset values
  localparam logic RST_WATCHDOG_ENABLE = 1'b1;
  localparam logic RST_SYNC_ERROR_LATCH_CLEAR = 1'b0;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;
  localparam logic [DATA_W-1:0] RST_ZERO_WORD = 32'h0000_0000;

  // Clock and the least hold time of the latch clear bit
  localparam int CLK_PERIOD_PS = 5000;
  localparam int LATCH_CLEAR_HOLD_NS = 500;
  localparam int LATCH_CLEAR_HOLD_CYC =
    (LATCH_CLEAR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CNT_W = 8;

  // Bus slave phase
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACCESS = 2'b10
  } apb_state_t;

endpackage

// file: design/sticky_flag.sv
// One sticky status bit with a clear pulse and a clear-hold level.
// Assumes set, clr and hold are synchronous to clk.
`timescale 1ns/10ps
module sticky_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic set,
  input wire logic clr,
  input wire logic hold,
  // State
  output logic flag
);

  logic flag_r;

  // Hold beats everything; a set beats a same-cycle clear pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (hold) begin
      flag_r <= 1'b0;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clr) begin
      flag_r <= 1'b0;
    end
  end

  assign flag = flag_r;

endmodule

// file: design/trigger_pulse.sv
// Self-clearing trigger: a write of one yields a single-cycle pulse.
// Assumes fire is a one-cycle write strobe qualified by the data bit.
`timescale 1ns/10ps
module trigger_pulse (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic fire,
  // Output pulse
  output logic pulse
);

  logic pulse_r;

  // Bit drops back to zero the cycle after it is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= fire;
    end
  end

  assign pulse = pulse_r;

endmodule

// file: verif/ctrl_regs_sva.sv
// Port checker for the control and self-test register group.
// Assumes a bind onto the top module and zero-wait APB transfers.
`timescale 1ns/10ps
module ctrl_regs_sva
  import ctrl_regs_pkg::*;
#(
  parameter logic [11:0] BUILD_NUMBER = 12'h000,
  parameter logic [7:0] MAJOR_VERSION = 8'h00,
  parameter logic [7:0] MINOR_VERSION = 8'h00
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctrl_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [ctrl_regs_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [ctrl_regs_pkg::DATA_W-1:0] prdata,
  // Block outputs
  input wire logic watchdog_enable,
  input wire logic integrity_test_trigger,
  input wire logic low_speed_bus_test_trigger,
  input wire logic sync_error_latch_clear
);
  logic wr_acc;
  logic rd_acc;
  // Only completed transfers carry an effect
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && pready && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_version_fields:
    assert property (rd_acc && paddr == ADDR_BITSTREAM_VERSION |->
      prdata == {4'h0, MINOR_VERSION, MAJOR_VERSION, BUILD_NUMBER}) else $error("version word wrong");
  a_watchdog_write:
    assert property (wr_acc && paddr == ADDR_MAIN_CONTROL && pstrb[0] |=>
      watchdog_enable == $past(pwdata[0])) else $error("watchdog bit not written");
  a_watchdog_reset:
    assert property ($rose(presetn) |-> watchdog_enable) else $error("watchdog not on after reset");
  a_integrity_launch:
    assert property (wr_acc && paddr == ADDR_SELF_TEST_TRIGGER && pstrb[0] && pwdata[0] |=>
      integrity_test_trigger) else $error("integrity trigger missing");
  a_bus_test_launch:
    assert property (wr_acc && paddr == ADDR_SELF_TEST_TRIGGER && pstrb[0] && pwdata[1] |=>
      low_speed_bus_test_trigger) else $error("bus test trigger missing");
  a_trigger_single:
    assert property (integrity_test_trigger || low_speed_bus_test_trigger |=>
      !integrity_test_trigger && !low_speed_bus_test_trigger) else $error("trigger longer than a cycle");
  a_trigger_read_zero:
    assert property (rd_acc && paddr == ADDR_SELF_TEST_TRIGGER |-> prdata == 32'h0)
    else $error("trigger readback not zero");
  a_clear_holds_zero:
    assert property (rd_acc && paddr == ADDR_SYNC_ERROR_STATUS && sync_error_latch_clear &&
      $past(sync_error_latch_clear, 2) |-> prdata == 32'h0) else $error("status not held clear");
  a_result_upper_zero:
    assert property (rd_acc && paddr == ADDR_LANE_TEST_RESULT_CH0 |-> prdata[31:8] == 24'h0)
    else $error("result upper bits set");
endmodule

bind controller_control_self_test_regs ctrl_regs_sva #(.BUILD_NUMBER(BUILD_NUMBER),
  .MAJOR_VERSION(MAJOR_VERSION), .MINOR_VERSION(MINOR_VERSION)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .watchdog_enable(watchdog_enable),
  .integrity_test_trigger(integrity_test_trigger), .low_speed_bus_test_trigger(low_speed_bus_test_trigger),
  .sync_error_latch_clear(sync_error_latch_clear));

// file: verif/controller_control_self_test_regs_tb_top.sv
// Self-checking bench for the control and self-test register group.
// Assumes the package and design files are compiled before it.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module controller_control_self_test_regs_tb_top;
  import ctrl_regs_pkg::*;
  localparam logic [11:0] BLD = 12'h5a3;
  localparam logic [7:0] MAJ = 8'h12;
  localparam logic [7:0] MNR = 8'h34;
  localparam logic [31:0] VER = {4'h0, MNR, MAJ, BLD};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic integrity_test_done = 1'b0;
  logic low_speed_bus_test_done = 1'b0;
  logic sync_error_event = 1'b0;
  logic [7:0] ch0_lane_pass = 8'h00;
  logic pready, pslverr, watchdog_enable, integrity_test_trigger, low_speed_bus_test_trigger;
  logic sync_error_latch_clear, irq, rerr;
  logic [31:0] prdata, rdat;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  controller_control_self_test_regs #(.LANES(8), .BUILD_NUMBER(BLD), .MAJOR_VERSION(MAJ),
    .MINOR_VERSION(MNR)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .watchdog_enable(watchdog_enable), .integrity_test_trigger(integrity_test_trigger),
    .low_speed_bus_test_trigger(low_speed_bus_test_trigger), .integrity_test_done(integrity_test_done),
    .low_speed_bus_test_done(low_speed_bus_test_done), .ch0_lane_pass(ch0_lane_pass),
    .sync_error_event(sync_error_event), .sync_error_latch_clear(sync_error_latch_clear), .irq(irq));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; answer taken while the access phase stands
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    rdat = prdata;
    rerr = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask

  // One-cycle pulse on an event input: 0 sync error, 1 integrity done, 2 bus test done
  task automatic fire(input int k);
    @(posedge pclk);
    if (k == 0) sync_error_event <= 1'b1;
    if (k == 1) integrity_test_done <= 1'b1;
    if (k == 2) low_speed_bus_test_done <= 1'b1;
    @(posedge pclk);
    sync_error_event <= 1'b0;
    integrity_test_done <= 1'b0;
    low_speed_bus_test_done <= 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(watchdog_enable, 1'b1)
    rd(ADDR_BITSTREAM_VERSION, VER);
    wr(ADDR_BITSTREAM_VERSION, 32'hffff_ffff);
    rd(ADDR_BITSTREAM_VERSION, VER);
    rd(ADDR_MAIN_CONTROL, 32'h1);
    rd(ADDR_SYNC_ERROR_STATUS, 32'h0);
    rd(ADDR_LANE_TEST_RESULT_CH0, 32'h0);
    $display("reset test done");
    wr(ADDR_MAIN_CONTROL, 32'hffff_fffe);
    @(negedge pclk);
    `CHK(watchdog_enable, 1'b0)
    rd(ADDR_MAIN_CONTROL, 32'h0);
    wr(ADDR_MAIN_CONTROL, 32'hffff_ffff);
    rd(ADDR_MAIN_CONTROL, 32'h1);
    // Byte 0 strobed off: the write completes but leaves the enable alone
    pstrb <= 4'he;
    wr(ADDR_MAIN_CONTROL, 32'h0);
    pstrb <= 4'hf;
    rd(ADDR_MAIN_CONTROL, 32'h1);
    $display("watchdog test done");
    // Each trigger alone, then both together
    for (int i = 1; i < 4; i++) begin
      wr(ADDR_SELF_TEST_TRIGGER, i);
      @(negedge pclk);
      `CHK({low_speed_bus_test_trigger, integrity_test_trigger}, i[1:0])
      @(negedge pclk);
      `CHK({low_speed_bus_test_trigger, integrity_test_trigger}, 2'b00)
    end
    rd(ADDR_SELF_TEST_TRIGGER, 32'h0);
    $display("trigger test done");
    fire(0);
    rd(ADDR_SYNC_ERROR_STATUS, 32'h1);
    wr(ADDR_SYNC_ERROR_STATUS, 32'h0);
    rd(ADDR_SYNC_ERROR_STATUS, 32'h1);
    wr(ADDR_SYNC_ERROR_CLEAR, 32'h1);
    @(negedge pclk);
    `CHK(sync_error_latch_clear, 1'b1)
    fire(0);
    rd(ADDR_SYNC_ERROR_STATUS, 32'h0);
    repeat (LATCH_CLEAR_HOLD_CYC) @(posedge pclk);
    wr(ADDR_SYNC_ERROR_CLEAR, 32'h0);
    rd(ADDR_SYNC_ERROR_CLEAR, 32'h0);
    rd(ADDR_SYNC_ERROR_STATUS, 32'h0);
    fire(0);
    rd(ADDR_SYNC_ERROR_STATUS, 32'h1);
    $display("sync error test done");
    ch0_lane_pass <= 8'ha5;
    fire(1);
    ch0_lane_pass <= 8'h3c;
    rd(ADDR_LANE_TEST_RESULT_CH0, 32'h0000_00a5);
    $display("lane result test done");
    // Pending sync error and integrity done, masked out so far
    rd(ADDR_IRQ_STATUS, 32'h3);
    fire(2);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 32'h4);
    @(negedge pclk);
    `CHK(irq, 1'b1)
    rd(ADDR_IRQ_STATUS, 32'h4);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    rd(32'h4000_0020, 32'h0);
    `CHK(rerr, 1'b1)
    $display("interrupt and unmapped test done");
    wr(ADDR_MAIN_CONTROL, 32'h0);
    @(negedge pclk);
    `CHK(watchdog_enable, 1'b0)
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    `CHK(watchdog_enable, 1'b1)
    @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_SYNC_ERROR_STATUS, 32'h0);
    rd(ADDR_LANE_TEST_RESULT_CH0, 32'h0);
    $display("second reset test done");
    wrap_up();
  end
endmodule
